// >>> design/sad_autodetect.sv
// Slave address detection, ID list store and error latching
`timescale 1ns/1ps
module sad_autodetect import sad_pkg::*; #(
    parameter int POR_CYCLES = POR_CYC,
    parameter int HOLD_CYCLES = SW_HOLD_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_set_switch,
    input wire logic i_autodetect_command,
    input wire logic i_error_reset_request,
    input wire logic i_link_error,
    input wire logic i_error_active,
    input wire logic [15:0] i_error_code,
    input wire logic i_rpt_valid,
    input wire logic [7:0] i_rpt_addr,
    input wire logic i_rpt_is_input,
    input wire logic i_rpt_last,
    input wire logic i_param_done,
    input wire logic i_slave_alarm,
    input wire logic i_param_access_error,
    input wire logic i_param_write_req,
    input wire logic [6:0] i_list_index,
    output logic o_set_led,
    output logic o_autodetect_busy,
    output logic o_scan_start,
    output logic o_param_refresh,
    output logic o_io_exchange_en,
    output logic o_param_write_grant,
    output logic o_param_write_reject,
    output logic o_no_id_error,
    output logic o_dup_id_error,
    output logic o_slave_alarm,
    output logic o_param_access_error,
    output logic [15:0] o_latest_error_id_word,
    output logic o_remote_ready_flag,
    output logic [15:0] o_connected_id_count_word,
    output logic [15:0] o_list_id
);
    // ==========================================================
    // Helpers
    function automatic logic [15:0] form_id(input logic [8:0] key);
        form_id = key[8] ? (ID_INPUT_BASE | {8'h00, key[7:0]}) : {8'h00, key[7:0]};
    endfunction : form_id

    function automatic logic is_block_code(input logic [15:0] code);
        is_block_code = (code == ERR_BLK_0) || (code == ERR_BLK_1) || (code == ERR_BLK_2)
            || (code == ERR_BLK_3) || (code == ERR_BLK_4);
    endfunction : is_block_code

    // ==========================================================
    // Synchronisers for pin and host inputs
    logic sw_s1, sw_s2, cmd_s1, cmd_s2, cmd_s3, erst_s1, erst_s2;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            {sw_s1, sw_s2, cmd_s1, cmd_s2, cmd_s3, erst_s1, erst_s2} <= 7'h00;
        end else begin
            sw_s1 <= i_set_switch;
            sw_s2 <= sw_s1;
            cmd_s1 <= i_autodetect_command;
            cmd_s2 <= cmd_s1;
            cmd_s3 <= cmd_s2;
            erst_s1 <= i_error_reset_request;
            erst_s2 <= erst_s1;
        end
    end

    // ==========================================================
    // State
    sad_state_t state, next_state;
    logic [31:0] por_cnt, next_por_cnt, hold_cnt, next_hold_cnt;
    logic por_done, next_por_done, sw_armed, next_sw_armed;
    logic [8:0] key, next_key;
    logic [7:0] count, next_count;
    logic [511:0] present, next_present;
    logic next_led, next_busy, next_scan_start, next_refresh, next_io_en;
    logic next_pw_grant, next_pw_reject, next_no_id, next_dup, next_alarm, next_perr;
    logic [15:0] next_latest_id;
    logic next_ready;
    logic wr_en, next_wr_en;
    logic [7:0] wr_addr, next_wr_addr;
    logic [15:0] wr_data, next_wr_data;
    logic sw_start, cmd_fall, start_req, start_ok, blocked, any_err;
    logic [8:0] rpt_key;

    always_comb begin
        next_state = state;
        next_por_cnt = por_cnt;
        next_por_done = por_done;
        next_hold_cnt = hold_cnt;
        next_sw_armed = sw_armed;
        next_key = key;
        next_count = count;
        next_present = present;
        next_scan_start = 1'b0;
        next_refresh = 1'b0;
        next_wr_en = 1'b0;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_latest_id = o_latest_error_id_word;
        sw_start = 1'b0;
        rpt_key = {i_rpt_is_input, i_rpt_addr};

        // Power-on quiet time
        if (!por_done) begin
            if (por_cnt == 32'(POR_CYCLES - 1)) begin
                next_por_done = 1'b1;
            end else begin
                next_por_cnt = por_cnt + 32'd1;
            end
        end

        // Switch must be held the full time; re-arm only after release
        if (!sw_s2) begin
            next_hold_cnt = 32'd0;
            next_sw_armed = 1'b1;
        end else if (sw_armed) begin
            if (hold_cnt == 32'(HOLD_CYCLES - 1)) begin
                sw_start = 1'b1;
                next_sw_armed = 1'b0;
            end else begin
                next_hold_cnt = hold_cnt + 32'd1;
            end
        end

        cmd_fall = cmd_s3 && !cmd_s2;
        start_req = sw_start || cmd_fall;
        blocked = i_error_active && is_block_code(i_error_code);
        start_ok = por_done && !i_link_error && !blocked;

        // Unset and duplicate flags: volatile, held across runs until an error reset request in SAD_IDLE
        next_no_id = o_no_id_error && !(erst_s2 && state == SAD_IDLE);
        next_dup = o_dup_id_error && !(erst_s2 && state == SAD_IDLE);

        case (state)
            SAD_IDLE: begin
                // Requests during a run are dropped, not queued
                if (start_req && start_ok) begin
                    next_state = SAD_SCAN;
                    next_scan_start = 1'b1;
                    next_present = '0;
                    next_count = 8'h00;
                end
            end
            SAD_SCAN: begin
                if (i_rpt_valid) begin
                    if (i_rpt_addr == ADDR_UNSET) begin
                        next_no_id = 1'b1;
                    end else if (present[rpt_key]) begin
                        next_dup = 1'b1;
                        next_latest_id = form_id(rpt_key);
                    end else begin
                        next_present[rpt_key] = 1'b1;
                    end
                end
                if (i_rpt_valid && i_rpt_last) begin
                    next_state = SAD_STORE;
                    next_key = 9'h000;
                end
            end
            SAD_STORE: begin
                // Walk all 512 ID keys up to KEY_LAST; list beyond the store depth is dropped
                if (present[key] && count < 8'(ID_SLOTS)) begin
                    next_wr_en = 1'b1;
                    next_wr_addr = count;
                    next_wr_data = form_id(key);
                    next_count = count + 8'h01;
                end
                next_key = key + 9'h001;
                if (key == KEY_LAST) begin
                    next_state = SAD_SAVE_CNT;
                end
            end
            SAD_SAVE_CNT: begin
                next_wr_en = 1'b1;
                next_wr_addr = 8'(ID_SLOTS);
                next_wr_data = {8'h00, count};
                next_state = SAD_REFRESH;
                next_refresh = 1'b1;
            end
            SAD_REFRESH: begin
                if (i_param_done) begin
                    next_state = SAD_IDLE;
                end
            end
            default: begin
                next_state = SAD_IDLE;
            end
        endcase

        next_busy = (next_state != SAD_IDLE);
        next_led = (next_state == SAD_SCAN) || (next_state == SAD_STORE)
            || (next_state == SAD_SAVE_CNT);
        next_io_en = (next_state == SAD_IDLE);

        next_pw_grant = i_param_write_req && por_done && !i_link_error
            && state == SAD_IDLE;
        next_pw_reject = i_param_write_req && !next_pw_grant;

        // Set wins over a clear arriving in the same cycle
        next_alarm = i_slave_alarm || (o_slave_alarm && !erst_s2);
        next_perr = i_param_access_error || (o_param_access_error && !erst_s2);

        any_err = next_alarm || next_perr || next_no_id || next_dup;
        next_ready = !any_err && (o_remote_ready_flag || !erst_s2);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= SAD_IDLE;
            por_cnt <= 32'd0;
            por_done <= 1'b0;
            hold_cnt <= 32'd0;
            sw_armed <= 1'b0;
            key <= 9'h000;
            count <= 8'h00;
            present <= '0;
            o_set_led <= 1'b0;
            o_autodetect_busy <= 1'b0;
            o_scan_start <= 1'b0;
            o_param_refresh <= 1'b0;
            o_io_exchange_en <= 1'b1;
            o_param_write_grant <= 1'b0;
            o_param_write_reject <= 1'b0;
            o_no_id_error <= 1'b0;
            o_dup_id_error <= 1'b0;
            o_slave_alarm <= 1'b0;
            o_param_access_error <= 1'b0;
            o_latest_error_id_word <= 16'h0000;
            o_remote_ready_flag <= 1'b1;
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 16'h0000;
        end else begin
            state <= next_state;
            por_cnt <= next_por_cnt;
            por_done <= next_por_done;
            hold_cnt <= next_hold_cnt;
            sw_armed <= next_sw_armed;
            key <= next_key;
            count <= next_count;
            present <= next_present;
            o_set_led <= next_led;
            o_autodetect_busy <= next_busy;
            o_scan_start <= next_scan_start;
            o_param_refresh <= next_refresh;
            o_io_exchange_en <= next_io_en;
            o_param_write_grant <= next_pw_grant;
            o_param_write_reject <= next_pw_reject;
            o_no_id_error <= next_no_id;
            o_dup_id_error <= next_dup;
            o_slave_alarm <= next_alarm;
            o_param_access_error <= next_perr;
            o_latest_error_id_word <= next_latest_id;
            o_remote_ready_flag <= next_ready;
            wr_en <= next_wr_en;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
        end
    end

    // ==========================================================
    // Retained ID list
    sad_id_mem #(.DW(16), .DEPTH(ID_SLOTS), .AW(SLOT_AW)) u_mem (
        .i_clk(i_clk),
        .i_wr_en(wr_en),
        .i_wr_addr(wr_addr),
        .i_wr_data(wr_data),
        .i_rd_addr({1'b0, i_list_index}),
        .o_rd_data(o_list_id),
        .o_count(o_connected_id_count_word)
    );

    // ==========================================================
    // Checks
    property p_unset_flag;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == SAD_SCAN && i_rpt_valid && i_rpt_addr == ADDR_UNSET) |=> o_no_id_error;
    endproperty
    a_unset_flag: assert property (p_unset_flag) else $error("unset address not flagged");

    property p_id_form;
        @(posedge i_clk) disable iff (!i_rst_n)
        (wr_en && wr_addr < 8'(ID_SLOTS)) |-> (wr_data[15:8] == 8'h00 || wr_data[15:8] == 8'h02);
    endproperty
    a_id_form: assert property (p_id_form) else $error("stored ID out of range");

    property p_run_begins;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == SAD_IDLE && cmd_s3 && !cmd_s2 && start_ok) |=> o_autodetect_busy && o_scan_start;
    endproperty
    a_run_begins: assert property (p_run_begins) else $error("run did not begin");

    property p_led_store;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == SAD_STORE) |-> o_set_led && o_autodetect_busy;
    endproperty
    a_led_store: assert property (p_led_store) else $error("LED dark during store");

    property p_refuse;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == SAD_IDLE && (i_link_error || !por_done)) |=> !o_autodetect_busy;
    endproperty
    a_refuse: assert property (p_refuse) else $error("run started while refused");

    property p_block_code;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == SAD_IDLE && i_error_active && i_error_code == ERR_BLK_3) |=> state == SAD_IDLE;
    endproperty
    a_block_code: assert property (p_block_code) else $error("run started on block code");

    property p_io_halt;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_autodetect_busy |-> !o_io_exchange_en;
    endproperty
    a_io_halt: assert property (p_io_halt) else $error("I/O exchange during run");

    property p_pw_reject;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_param_write_req && o_autodetect_busy) |=> o_param_write_reject && !o_param_write_grant;
    endproperty
    a_pw_reject: assert property (p_pw_reject) else $error("param write not rejected");

    property p_alarm_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_slave_alarm && !erst_s2) |=> o_slave_alarm;
    endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped early");

    property p_clear_cause;
        @(posedge i_clk) disable iff (!i_rst_n)
        (erst_s2 && !i_param_access_error) |=> !o_param_access_error;
    endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("error not cleared");

    property p_count_saved;
        @(posedge i_clk) disable iff (!i_rst_n)
        (state == SAD_SAVE_CNT) |-> ##3 o_connected_id_count_word == {8'h00, $past(count, 3)};
    endproperty
    a_count_saved: assert property (p_count_saved) else $error("count word not saved");
endmodule : sad_autodetect

// >>> design/sad_id_mem.sv
// Nonvolatile ID list store with a count word kept past the last slot
`timescale 1ns/1ps
module sad_id_mem #(
    parameter int DW = 16,
    parameter int DEPTH = 128,
    parameter int AW = 8
) (
    input wire logic i_clk,
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [DW-1:0] i_wr_data,
    input wire logic [AW-1:0] i_rd_addr,
    output logic [DW-1:0] o_rd_data,
    output logic [DW-1:0] o_count
);
    // ==========================================================
    // Storage
    // No reset: contents stand for the retained list across power cycles
    logic [DW-1:0] mem [0:DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        o_rd_data <= mem[i_rd_addr];
        o_count <= mem[DEPTH];
    end
endmodule : sad_id_mem

// >>> design/sad_pkg.sv
// Shared constants for the slave address detection block
package sad_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_KHZ = 100_000;
    localparam int POR_MS = 5000;
    localparam int POR_CYC = POR_MS * CLK_KHZ;
    localparam int SW_HOLD_MS = 1000;
    localparam int SW_HOLD_CYC = SW_HOLD_MS * CLK_KHZ;

    // ==========================================================
    // Addresses and IDs
    localparam logic [7:0] ADDR_UNSET = 8'hff;
    localparam logic [15:0] ID_INPUT_BASE = 16'h0200;
    localparam int ID_SLOTS = 128;
    localparam int SLOT_AW = 8;
    localparam logic [8:0] KEY_LAST = 9'h1ff;

    // ==========================================================
    // Error codes that forbid a detection run
    localparam logic [15:0] ERR_BLK_0 = 16'h0064;
    localparam logic [15:0] ERR_BLK_1 = 16'h0065;
    localparam logic [15:0] ERR_BLK_2 = 16'h0066;
    localparam logic [15:0] ERR_BLK_3 = 16'h00c8;
    localparam logic [15:0] ERR_BLK_4 = 16'h00c9;

    // ==========================================================
    // Detection sequence states
    typedef enum logic [4:0] {
        SAD_IDLE = 5'b00001,
        SAD_SCAN = 5'b00010,
        SAD_STORE = 5'b00100,
        SAD_SAVE_CNT = 5'b01000,
        SAD_REFRESH = 5'b10000
    } sad_state_t;
endpackage : sad_pkg

// >>> test/sad_autodetect_bench.sv
// Self-checking bench for the slave address detection block
`timescale 1ns/1ps
module sad_autodetect_bench;
    import sad_pkg::*;
    // ==========================================================
    // Stimulus and observation
    logic i_clk, i_rst_n, i_set_switch, i_autodetect_command, i_error_reset_request;
    logic i_link_error, i_error_active, i_rpt_valid, i_rpt_is_input, i_rpt_last;
    logic i_param_done, i_slave_alarm, i_param_access_error, i_param_write_req, faulty;
    logic [15:0] i_error_code;
    logic [7:0] i_rpt_addr;
    logic [6:0] i_list_index;
    logic o_set_led, o_autodetect_busy, o_scan_start, o_param_refresh, o_io_exchange_en;
    logic o_param_write_grant, o_param_write_reject, o_no_id_error, o_dup_id_error;
    logic o_slave_alarm, o_param_access_error, o_remote_ready_flag;
    logic [15:0] o_latest_error_id_word, o_connected_id_count_word, o_list_id;
    int bad_count = 0;
    int comparisons = 0;
    localparam logic [15:0] EXP_ID [4] = '{16'h0000, 16'h0002, 16'h0200, 16'h02fe};
    localparam logic [15:0] BLK [5] = '{ERR_BLK_0, ERR_BLK_1, ERR_BLK_2, ERR_BLK_3, ERR_BLK_4};

    sad_autodetect #(.POR_CYCLES(20), .HOLD_CYCLES(4)) dut (.*);
    sad_slave_link link (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scan_start(o_scan_start),
        .i_param_refresh(o_param_refresh), .i_faulty(faulty), .o_rpt_valid(i_rpt_valid),
        .o_rpt_addr(i_rpt_addr), .o_rpt_is_input(i_rpt_is_input), .o_rpt_last(i_rpt_last),
        .o_param_done(i_param_done));

    initial i_clk = 1'b0;
    always #5 i_clk = ~i_clk;

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick

    task automatic wait_busy(input logic lvl);
        int k;
        k = 0;
        while (o_autodetect_busy !== lvl && k < 3000) begin
            tick(1);
            k++;
        end
        check(16'(k == 3000), 16'h0);
    endtask : wait_busy

    task automatic cmd_pulse(input int hold);
        @(posedge i_clk) i_autodetect_command <= 1'b1;
        tick(hold);
        @(posedge i_clk) i_autodetect_command <= 1'b0;
    endtask : cmd_pulse

    task automatic param_write(input logic grant);
        @(posedge i_clk) i_param_write_req <= 1'b1;
        @(posedge i_clk) i_param_write_req <= 1'b0;
        #1;
        check(o_param_write_grant, grant);
        check(o_param_write_reject, !grant);
    endtask : param_write

    task automatic conclude();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    // ==========================================================
    // Watchdog: the sequence needs under 4000 cycles
    initial begin
        tick(20000);
        bad_count++;
        conclude();
    end

    // ==========================================================
    // Main sequence
    initial begin
        {i_rst_n, i_set_switch, i_autodetect_command, i_error_reset_request} = '0;
        {i_link_error, i_error_active, i_slave_alarm, i_param_access_error} = '0;
        {i_param_write_req, faulty} = '0;
        i_error_code = 16'h0000;
        i_list_index = 7'h00;
        tick(6);
        @(posedge i_clk) i_rst_n <= 1'b1;
        tick(1);
        check(o_autodetect_busy, 1'b0);
        check(o_set_led, 1'b0);
        check(o_io_exchange_en, 1'b1);
        check(o_remote_ready_flag, 1'b1);
        // Requests in the power-on window are dropped
        param_write(1'b0);
        cmd_pulse(2);
        tick(8);
        check(o_autodetect_busy, 1'b0);
        tick(20);
        @(posedge i_clk) i_link_error <= 1'b1;
        param_write(1'b0);
        cmd_pulse(2);
        tick(8);
        check(o_autodetect_busy, 1'b0);
        @(posedge i_clk) i_link_error <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            @(posedge i_clk) i_error_active <= 1'b1;
            i_error_code <= BLK[i];
            cmd_pulse(2);
            tick(8);
            check(o_autodetect_busy, 1'b0);
        end
        // A code outside the list does not block; a long hold is one request
        @(posedge i_clk) i_error_code <= 16'h0067;
        cmd_pulse(30);
        wait_busy(1'b1);
        check(o_set_led, 1'b1);
        check(o_io_exchange_en, 1'b0);
        param_write(1'b0);
        cmd_pulse(3);
        tick(570);
        check(o_set_led, 1'b0);
        check(o_autodetect_busy, 1'b1);
        wait_busy(1'b0);
        check(o_io_exchange_en, 1'b1);
        tick(10);
        check(o_autodetect_busy, 1'b0);
        check(o_connected_id_count_word, 16'h0004);
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk) i_list_index <= 7'(i);
            tick(1);
            check(o_list_id, EXP_ID[i]);
        end
        check(o_no_id_error, 1'b0);
        param_write(1'b1);
        // Switch run over a link with an unset and a doubled address
        @(posedge i_clk) faulty <= 1'b1;
        i_set_switch <= 1'b1;
        wait_busy(1'b1);
        check(o_set_led, 1'b1);
        @(posedge i_clk) i_set_switch <= 1'b0;
        wait_busy(1'b0);
        check(o_no_id_error, 1'b1);
        check(o_dup_id_error, 1'b1);
        check(o_latest_error_id_word, 16'h0005);
        check(o_connected_id_count_word, 16'h0001);
        check(o_remote_ready_flag, 1'b0);
        @(posedge i_clk) i_error_reset_request <= 1'b1;
        tick(6);
        check(o_no_id_error, 1'b0);
        check(o_dup_id_error, 1'b0);
        check(o_remote_ready_flag, 1'b0);
        @(posedge i_clk) i_error_reset_request <= 1'b0;
        tick(6);
        check(o_remote_ready_flag, 1'b1);
        // Alarm and access error latch, then clear only once the cause is gone
        @(posedge i_clk) {i_slave_alarm, i_param_access_error} <= 2'b11;
        @(posedge i_clk) {i_slave_alarm, i_param_access_error} <= 2'b00;
        tick(10);
        check(o_slave_alarm, 1'b1);
        check(o_param_access_error, 1'b1);
        @(posedge i_clk) {i_slave_alarm, i_param_access_error} <= 2'b11;
        i_error_reset_request <= 1'b1;
        tick(6);
        check(o_slave_alarm, 1'b1);
        check(o_param_access_error, 1'b1);
        @(posedge i_clk) {i_slave_alarm, i_param_access_error} <= 2'b00;
        tick(3);
        check(o_slave_alarm, 1'b0);
        check(o_param_access_error, 1'b0);
        @(posedge i_clk) i_error_reset_request <= 1'b0;
        tick(6);
        check(o_remote_ready_flag, 1'b1);
        conclude();
    end
endmodule : sad_autodetect_bench

// >>> test/sad_slave_link.sv
// Behavioural model of the slave link: scan report stream and refresh completion
`timescale 1ns/1ps
module sad_slave_link (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_scan_start,
    input wire logic i_param_refresh,
    input wire logic i_faulty,
    output logic o_rpt_valid,
    output logic [7:0] o_rpt_addr,
    output logic o_rpt_is_input,
    output logic o_rpt_last,
    output logic o_param_done
);
    // ==========================================================
    // Slave table as {is_input, address}; entries 4..6 hold an unset and a doubled address
    logic [8:0] tbl [7];
    int idx;
    int wait_c;
    int ref_c;
    bit active;
    // Addresses stay as set until the table is rewritten
    initial tbl = '{9'h000, 9'h002, 9'h100, 9'h1fe, 9'h005, 9'h0ff, 9'h005};

    // ==========================================================
    // Reports go back to back; refresh answers slowly so the LED-off window is wide
    always @(posedge i_clk) begin
        o_rpt_valid <= 1'b0;
        o_rpt_last <= 1'b0;
        o_param_done <= 1'b0;
        // Idle lines do not keep the last value
        o_rpt_addr <= ~o_rpt_addr;
        o_rpt_is_input <= ~o_rpt_is_input;
        if (!i_rst_n) begin
            active <= 1'b0;
            ref_c <= 0;
            o_rpt_addr <= 8'h5a;
            o_rpt_is_input <= 1'b0;
        end else begin
            if (i_scan_start) begin
                active <= 1'b1;
                idx <= i_faulty ? 4 : 0;
                wait_c <= 3;
            end else if (active && wait_c > 0) begin
                wait_c <= wait_c - 1;
            end else if (active) begin
                o_rpt_valid <= 1'b1;
                {o_rpt_is_input, o_rpt_addr} <= tbl[idx];
                o_rpt_last <= (idx == 3) || (idx == 6);
                if ((idx == 3) || (idx == 6)) begin
                    active <= 1'b0;
                end
                idx <= idx + 1;
            end
            if (i_param_refresh) begin
                ref_c <= 100;
            end else if (ref_c > 0) begin
                ref_c <= ref_c - 1;
                o_param_done <= (ref_c == 1);
            end
        end
    end
endmodule : sad_slave_link
